// ===== clock_gate_status.sv
// peripheral clock gates, clock event status and interrupt logic
// assumes power_mode and cpu_sleep come from logic on hclk,
// crystal_stable and pll_locked come straight from analog pins
`timescale 1ns/1ps
`include "clk_map.svh"
module clock_gate_status (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // bus
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // power and pins
   input  wire logic [1:0]  power_mode,
   input  wire logic        cpu_sleep,
   input  wire logic        crystal_stable,
   input  wire logic        pll_locked,
   // clock enables and interrupt
   output logic             serial_a_user_clock_en,
   output logic             serial_b_user_clock_en,
   output logic             sys_bus_clock_en,
   output logic             periph_bus_clock_en,
   output logic             irq
);
   // ==========================================
   // helpers and carriers
   reg_if rb ();
   ev_if  ev ();

   clk_pkg::core_s  st;
   clk_pkg::core_s  next_st;
   clk_pkg::reg16_t events;
   clk_pkg::reg16_t w1c;
   logic            deep;
   logic            sleep_req;
   logic            hsize_unused;

   // whole-word transfers only, so size carries no information here
   assign hsize_unused = |hsize;

   ahb_front u_front (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ce        (ce),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hwdata    (hwdata),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .rb        (rb)
   );

   // pins pass two flops before anything looks at them
   status_sync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .raw     ({crystal_stable, pll_locked}),
      .ev      (ev)
   );

   // ==========================================
   // event vector in the status layout
   // unlock only on a falling lock edge
   // lock only on a rising lock edge
   always_comb begin
      events                     = 16'h0000;
      events[`PLL_LOCK_BIT]      = ev.rise[0];
      events[`PLL_UNLOCK_BIT]    = ev.fall[0];
      events[`XTAL_OK_BIT]       = ev.rise[1];
      events[`XTAL_NOK_BIT]      = ev.fall[1];
   end

   // write-one-to-clear pattern, limited to the sticky bits
   assign w1c = (rb.wr_req && rb.wr_addr == `STAT_ADDR) ?
                (rb.wr_data[15:0] & `EVENT_BITS) : 16'h0000;

   assign deep      = power_mode[`DEEP_MODE_BIT];
   assign sleep_req = (power_mode == `SYSTEM_SLEEP_MODE) && cpu_sleep;

   // ==========================================
   // next state of the register core
   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.stat = ((st.stat & ~w1c) | events) & `EVENT_BITS;
         next_st.stat[`XTAL_NOW_BIT] = ev.level[1];
         next_st.stat[`PLL_NOW_BIT]  = ev.level[0];

         // interrupt status clears on read, a new event still lands
         if (rb.rd_req && rb.rd_addr == `IRQS_ADDR) begin
            next_st.irqs = events;
         end else begin
            next_st.irqs = st.irqs | events;
         end

         // plain read-write registers
         if (rb.wr_req && rb.wr_addr == `GATE_ADDR) begin
            next_st.gates = rb.wr_data[15:0] & `GATE_BITS;
         end
         if (rb.wr_req && rb.wr_addr == `MASK_ADDR) begin
            next_st.mask = rb.wr_data[15:0] & `EVENT_BITS;
         end

         next_st.irq = |(next_st.irqs & next_st.mask);

         // gate bit 1 in modes 0 and 1
         next_st.b_en = ~deep & ~next_st.gates[`GATE_B_BIT];
         // gate bit 0 in modes 0 and 1
         next_st.a_en = ~deep & ~next_st.gates[`GATE_A_BIT];

         // bus clocks follow processor sleep in mode 2
         case (st.bus_st)
            clk_pkg::BUS_RUN: begin
               if (sleep_req) begin
                  next_st.bus_st = clk_pkg::BUS_GATED;
               end
            end
            clk_pkg::BUS_GATED: begin
               if (!sleep_req) begin
                  next_st.bus_st = clk_pkg::BUS_RUN;
               end
            end
            default: begin
               next_st.bus_st = clk_pkg::BUS_RUN;
            end
         endcase
         next_st.bus_en = (next_st.bus_st == clk_pkg::BUS_RUN);
      end
   end

   // ==========================================
   // state register
   // status starts at zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st        <= '0;
         st.gates  <= `GATE_RESET;
         st.stat   <= `STAT_RESET;
         st.mask   <= `MASK_RESET;
         st.irqs   <= `IRQS_RESET;
         st.bus_st <= clk_pkg::BUS_RUN;
         st.bus_en <= 1'b1;
         st.a_en   <= 1'b1;
         st.b_en   <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================
   // read mux; gates, status and mask use next values so a write just ahead is seen
   // reserved bits read zero
   always_comb begin
      case (rb.rd_addr)
         `GATE_ADDR: rb.rd_data = {16'h0000, next_st.gates};
         `STAT_ADDR: rb.rd_data = {16'h0000, next_st.stat};
         `MASK_ADDR: rb.rd_data = {16'h0000, next_st.mask};
         `IRQS_ADDR: rb.rd_data = {16'h0000, st.irqs | events};
         default:    rb.rd_data = 32'h0000_0000;
      endcase
   end

   // outputs straight from the state register
   assign serial_a_user_clock_en = st.a_en;
   assign serial_b_user_clock_en = st.b_en;
   assign sys_bus_clock_en       = st.bus_en;
   assign periph_bus_clock_en    = st.bus_en;
   assign irq                    = st.irq;

   // ==========================================
   // checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // user gates in the light modes
   gate_b_user_a: assert property (
      ce && !deep |=> serial_b_user_clock_en == !st.gates[`GATE_B_BIT])
      else $error("serial b clock does not follow its gate bit");
   gate_a_user_a: assert property (
      ce && !deep |=> serial_a_user_clock_en == !st.gates[`GATE_A_BIT])
      else $error("serial a clock does not follow its gate bit");

   // deep modes force both clocks off whatever the gate bits say
   gate_b_deep_a: assert property (
      ce && deep |=> !serial_b_user_clock_en)
      else $error("serial b clock runs in a deep mode");
   gate_a_deep_a: assert property (
      ce && deep |=> !serial_a_user_clock_en)
      else $error("serial a clock runs in a deep mode");

   // crystal events
   xtal_drop_set_a: assert property (
      ce && ev.fall[1] |=> st.stat[`XTAL_NOK_BIT])
      else $error("crystal drop not recorded");
   xtal_rise_set_a: assert property (
      ce && ev.rise[1] |=> st.stat[`XTAL_OK_BIT])
      else $error("crystal rise not recorded");
   xtal_irq_raise_a: assert property (
      ce && ev.rise[1] && st.mask[`XTAL_OK_BIT] |=> irq)
      else $error("enabled crystal event raised no interrupt");
   xtal_live_a: assert property (
      ce |=> st.stat[`XTAL_NOW_BIT] == $past(ev.level[1]))
      else $error("crystal live bit lags its input");

   // pll events
   pll_unlock_set_a: assert property (
      ce && ev.fall[0] |=> st.stat[`PLL_UNLOCK_BIT])
      else $error("pll lock loss not recorded");
   unlock_cause_a: assert property (
      $rose(st.stat[`PLL_UNLOCK_BIT]) |-> $past(ev.fall[0]) && $past(ce))
      else $error("unlock bit set without a lock loss");
   pll_lock_set_a: assert property (
      ce && ev.rise[0] |=> st.stat[`PLL_LOCK_BIT])
      else $error("pll lock gain not recorded");
   lock_cause_a: assert property (
      $rose(st.stat[`PLL_LOCK_BIT]) |-> $past(ev.rise[0]) && $past(ce))
      else $error("lock bit set without a fresh lock");
   pll_live_a: assert property (
      ce |=> st.stat[`PLL_NOW_BIT] == $past(ev.level[0]))
      else $error("pll live bit lags its input");

   // reserved bits and reset value
   reserved_zero_a: assert property (
      st.stat[15] == 1'b0 && st.stat[11:3] == 9'h000)
      else $error("reserved status bit set");
   status_reset_a: assert property (
      @(posedge hclk) $rose(hresetn) |-> st.stat == `STAT_RESET)
      else $error("status not zero after reset");

   // bus clocks
   bus_gate_a: assert property (
      ce && sleep_req |=> !sys_bus_clock_en && !periph_bus_clock_en)
      else $error("bus clocks run during system sleep");

   // simultaneous set and clear
   set_wins_a: assert property (
      ce && ev.rise[0] && w1c[`PLL_LOCK_BIT] |=> st.stat[`PLL_LOCK_BIT])
      else $error("clear beat a same-cycle lock event");
endmodule

// ===== clk_map.svh
// constants for the clock gate and clock status block
// assumes byte addresses on a 32-bit word bus, one register per word
`ifndef CLK_MAP_SVH
`define CLK_MAP_SVH
// ==========================================
// register byte addresses
`define GATE_ADDR          32'h4002_8014
`define STAT_ADDR          32'h4002_8018
`define MASK_ADDR          32'h4002_801C
`define IRQS_ADDR          32'h4002_8020
// ==========================================
// field positions
`define GATE_A_BIT         0
`define GATE_B_BIT         1
`define PLL_NOW_BIT        0
`define PLL_LOCK_BIT       1
`define PLL_UNLOCK_BIT     2
`define XTAL_NOW_BIT       12
`define XTAL_OK_BIT        13
`define XTAL_NOK_BIT       14
`define DEEP_MODE_BIT      1
// ==========================================
// reset values and masks
`define STAT_RESET         16'h0000
`define GATE_RESET         16'h0000
`define MASK_RESET         16'h0000
`define IRQS_RESET         16'h0000
`define EVENT_BITS         16'h6006
`define GATE_BITS          16'h0003
`define SYSTEM_SLEEP_MODE  2'h2
`endif

// ===== clk_pkg.sv
// types shared by the clock gate and status block
// assumes clk_map.svh supplies every number
package clk_pkg;
   typedef logic [15:0] reg16_t;
   // ==========================================
   // bus clock gating state
   typedef enum logic {BUS_RUN, BUS_GATED} bus_state_e;
   // ==========================================
   // state of the register core
   typedef struct packed {
      reg16_t     gates;
      reg16_t     stat;
      reg16_t     mask;
      reg16_t     irqs;
      logic       irq;
      logic       a_en;
      logic       b_en;
      logic       bus_en;
      bus_state_e bus_st;
   } core_s;
   // state of the input synchroniser
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] last;
   } sync_s;
   // state of the bus front end
   typedef struct packed {
      logic        wr_pend;
      logic [31:0] wr_addr;
      logic [31:0] rdata;
      logic        ready;
   } front_s;
endpackage

// ===== carrier_if.sv
// carriers between the register core and its two helpers
// assumes all three sit on hclk
`timescale 1ns/1ps
// ==========================================
// register access strobes
interface reg_if;
   logic        rd_req;
   logic [31:0] rd_addr;
   logic [31:0] rd_data;
   logic        wr_req;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   modport front (output rd_req, rd_addr, wr_req, wr_addr, wr_data, input rd_data);
   modport core  (input rd_req, rd_addr, wr_req, wr_addr, wr_data, output rd_data);
endinterface
// ==========================================
// synchronised levels and edges, bit 0 pll, bit 1 crystal
interface ev_if;
   logic [1:0] level;
   logic [1:0] rise;
   logic [1:0] fall;
   modport src  (output level, rise, fall);
   modport sink (input level, rise, fall);
endinterface

// ===== status_sync.sv
// two-stage synchroniser and edge finder for the status pins
// assumes raw inputs are asynchronous to hclk
`timescale 1ns/1ps
module status_sync (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       ce,
   input  wire logic [1:0] raw,
   ev_if.src               ev
);
   clk_pkg::sync_s st;
   clk_pkg::sync_s next_st;

   // first stage feeds only the second
   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.s1   = raw;
         next_st.s2   = st.s1;
         next_st.last = st.s2;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // edges per input, taken from the settled stages only
   for (genvar i = 0; i < 2; i++) begin : g_edge
      assign ev.level[i] = st.s2[i];
      assign ev.rise[i]  = st.s2[i] & ~st.last[i];
      assign ev.fall[i]  = ~st.s2[i] & st.last[i];
   end
endmodule

// ===== ahb_front.sv
// AHB-Lite slave front end, zero wait states, always OKAY
// assumes one slave, single word transfers only
`timescale 1ns/1ps
`include "clk_map.svh"
module ahb_front (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   reg_if.front             rb
);
   clk_pkg::front_s st;
   clk_pkg::front_s next_st;
   logic            take;

   // address phase taken on NONSEQ or SEQ while the bus is ready
   assign take       = hsel & htrans[1] & hready & ce;
   assign rb.rd_req  = take & ~hwrite;
   assign rb.rd_addr = haddr;
   // writes land at the end of the data phase, when hwdata stands
   assign rb.wr_req  = st.wr_pend & ce;
   assign rb.wr_addr = st.wr_addr;
   assign rb.wr_data = hwdata;

   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.ready   = 1'b1;
         next_st.wr_pend = take & hwrite;
         next_st.wr_addr = haddr;
         next_st.rdata   = rb.rd_req ? rb.rd_data : 32'h0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st       <= '0;
         st.ready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata    = st.rdata;
   assign hreadyout = st.ready;
   assign hresp     = 1'b0;
endmodule

// ===== testbench.sv
// self-checking bench for the clock gate and clock status block
// assumes one bus master here, hready looped back from hreadyout, ce high but for one lost write
`timescale 1ns/1ps
`include "clk_map.svh"
module testbench;
   // ==========================================
   // signals and bookkeeping
   typedef struct {
      string       what;
      logic        kind;
      logic [31:0] exp;
   } note_s;
   logic        hclk           = 1'b0;
   logic        hresetn        = 1'b0;
   logic        ce             = 1'b1;
   logic        hsel           = 1'b0;
   logic [31:0] haddr          = 32'h0;
   logic [1:0]  htrans         = 2'h0;
   logic        hwrite         = 1'b0;
   logic [31:0] hwdata         = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [1:0]  power_mode     = 2'h0;
   logic        cpu_sleep      = 1'b0;
   logic        crystal_stable = 1'b0;
   logic        pll_locked     = 1'b0;
   logic        a_en;
   logic        b_en;
   logic        sys_en;
   logic        per_en;
   logic        irq;
   logic        rd_phase       = 1'b0;
   logic        probe          = 1'b0;
   logic [31:0] rnd;
   logic [1:0]  m;
   logic [1:0]  g;
   logic        s;
   note_s       cur;
   note_s       q[$];
   int          num_errors     = 0;
   int          compares       = 0;

   // 250 MHz clock
   always #2 hclk = ~hclk;

   // ==========================================
   // device under test
   clock_gate_status u_clock_gate_status (
      .hclk                   (hclk),
      .hresetn                (hresetn),
      .ce                     (ce),
      .hsel                   (hsel),
      .haddr                  (haddr),
      .htrans                 (htrans),
      .hwrite                 (hwrite),
      .hsize                  (3'h2),
      .hready                 (hreadyout),
      .hwdata                 (hwdata),
      .hrdata                 (hrdata),
      .hreadyout              (hreadyout),
      .hresp                  (hresp),
      .power_mode             (power_mode),
      .cpu_sleep              (cpu_sleep),
      .crystal_stable         (crystal_stable),
      .pll_locked             (pll_locked),
      .serial_a_user_clock_en (a_en),
      .serial_b_user_clock_en (b_en),
      .sys_bus_clock_en       (sys_en),
      .periph_bus_clock_en    (per_en),
      .irq                    (irq)
   );

   // ==========================================
   // comparison, verdict and watchdog
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // the whole run is well under 2000 cycles, so a hang is caught early
   initial begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      results();
   end

   // monitor: oldest note is matched against whatever result shows at this edge
   always @(posedge hclk) begin
      if (rd_phase || probe) begin
         cur = q.pop_front();
         if (cur.kind) begin
            check(cur.what, {26'h0, hresp, a_en, b_en, sys_en, per_en, irq}, cur.exp);
         end else begin
            check(cur.what, hrdata, cur.exp);
         end
      end
   end

   // ==========================================
   // bus master and output probe
   // the master never assumes a latency, it waits for hready each phase
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                      input string what, input logic [31:0] e);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) begin
         q.push_back('{what, 1'b0, e});
         rd_phase <= 1'b1;
      end
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_phase <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, "", 32'h0);
   endtask

   task automatic rd(input logic [31:0] a, input string what, input logic [31:0] e);
      bus(a, 1'b0, 32'h0, what, e);
   endtask

   // one spare edge first so registered enables and irq have settled
   task automatic peek(input string what, input logic [4:0] e);
      @(posedge hclk);
      q.push_back('{what, 1'b1, {27'h0, e}});
      probe <= 1'b1;
      @(posedge hclk);
      probe <= 1'b0;
   endtask

   // pin changes need sync plus edge detect before they show
   task automatic settle;
      repeat (5) @(posedge hclk);
   endtask

   // ==========================================
   // main sequence
   initial begin
      void'($urandom(32'h5E3519CD));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // all four registers clear after reset
      for (int k = 0; k < 4; k++) begin
         rd(`GATE_ADDR + 32'(4 * k), "reset value", 32'h0);
      end
      peek("enables after reset", 5'h1E);
      // random data, only the defined bits may stick
      rnd = $urandom();
      wr(`GATE_ADDR, rnd);
      rd(`GATE_ADDR, "gates", {16'h0, rnd[15:0] & `GATE_BITS});
      rnd = $urandom();
      wr(`MASK_ADDR, rnd);
      rd(`MASK_ADDR, "mask", {16'h0, rnd[15:0] & `EVENT_BITS});
      wr(`MASK_ADDR, 32'h0);
      // sweep of gate bits, power modes and sleep
      for (int i = 0; i < 32; i++) begin
         m = i[1:0];
         g = i[3:2];
         s = i[4];
         wr(`GATE_ADDR, {30'h0, g});
         power_mode <= m;
         cpu_sleep  <= s;
         @(posedge hclk);
         peek("mode sweep", {m < 2'h2 && !g[0], m < 2'h2 && !g[1], !(m == 2'h2 && s), !(m == 2'h2 && s), 1'b0});
      end
      power_mode <= 2'h0;
      cpu_sleep  <= 1'b0;
      wr(`GATE_ADDR, 32'h0);
      wr(`MASK_ADDR, {16'h0, `EVENT_BITS});
      // lock event and live lock bit
      pll_locked <= 1'b1;
      settle();
      rd(`STAT_ADDR, "status lock", 32'h3);
      peek("irq on lock", 5'h1F);
      rd(`IRQS_ADDR, "irq status", 32'h2);
      peek("irq after read", 5'h1E);
      // writes to live and reserved bits have no effect
      wr(`STAT_ADDR, 32'hFFFF_FFFF);
      rd(`STAT_ADDR, "status w1c", 32'h1);
      settle();
      rd(`STAT_ADDR, "no second lock", 32'h1);
      // unlock event, then no repeat until a fresh lock
      pll_locked <= 1'b0;
      settle();
      rd(`STAT_ADDR, "status unlock", 32'h4);
      wr(`STAT_ADDR, 32'h4);
      settle();
      rd(`STAT_ADDR, "no second unlock", 32'h0);
      pll_locked <= 1'b1;
      settle();
      pll_locked <= 1'b0;
      settle();
      rd(`STAT_ADDR, "relock then loss", 32'h6);
      rd(`IRQS_ADDR, "irq status pll", 32'h6);
      wr(`STAT_ADDR, 32'h0000_FFFF);
      crystal_stable <= 1'b1;
      settle();
      rd(`STAT_ADDR, "crystal stable", 32'h3000);
      peek("irq crystal ok", 5'h1F);
      rd(`IRQS_ADDR, "irq status ok", 32'h2000);
      // crystal loss while masked, then unmasked
      wr(`MASK_ADDR, 32'h0);
      crystal_stable <= 1'b0;
      settle();
      peek("irq masked", 5'h1E);
      rd(`STAT_ADDR, "crystal lost", 32'h6000);
      wr(`MASK_ADDR, 32'h4000);
      peek("irq unmasked", 5'h1F);
      wr(`STAT_ADDR, 32'h4000);
      rd(`STAT_ADDR, "w1c one bit", 32'h2000);
      // unmapped place reads zero and swallows writes
      wr(`IRQS_ADDR + 32'h4, $urandom());
      rd(`IRQS_ADDR + 32'h4, "unmapped", 32'h0);
      rd(`IRQS_ADDR, "irq status nok", 32'h4000);
      peek("irq cleared", 5'h1E);
      // lock edge lands in the very cycle its write-one clear is applied
      pll_locked <= 1'b1;
      @(posedge hclk);
      wr(`STAT_ADDR, 32'h0000_0002);
      rd(`STAT_ADDR, "set beats clear", 32'h2003);
      // a write made while the clock enable is low is lost
      ce <= 1'b0;
      wr(`GATE_ADDR, 32'h0000_0003);
      ce <= 1'b1;
      rd(`GATE_ADDR, "frozen gates", 32'h0);
      results();
   end
endmodule
